/* File: design/fbm_manager.sv */
// frame buffer and raw capture manager
`timescale 1ns/1ps
// What this block does
// - raw capture only when enable is one
// - channel select 0..15 picks sampled channel
// - raw only between first and last line
// - raw storage starts at first pixel
// - raw count rounded up to 1024
// - raw sample is 16 bits, taken only in cycles without a pixel strobe
// - three 512 MB buffers at upper region
// - frame start locks next buffer, records info
// - set done flag when frame complete
// - status reports geometry, time, counts, done
// - lines written count kept current
// - held buffer never overwritten
// - normal bases A0, C0, E0 million
// - raw data at base plus raw offset
// - large layout gives two 768 MB buffers
// - large bases A0 and D0, third unused
// - count pixels and lines to completion
// - sample size selects 16 or 32 bits
module fbm_manager (
  // clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // control strobes and pixel data
  input wire logic FRAME_MARK,
  input wire logic LINE_MARK,
  input wire logic PIXEL_STROBE,
  input wire logic [31:0] PIXEL_DATA,
  input wire logic [31:0] TIMESTAMP,
  // converter samples, sixteen channels
  input wire logic [255:0] ADC_SAMPLES,
  // configuration
  input wire logic [15:0] PIXELS_PER_OUTPUT,
  input wire logic [15:0] LINES_PER_OUTPUT,
  input wire logic SAMPLE_SIZE_SELECT,
  input wire logic LARGE_BUFFER_LAYOUT,
  input wire logic RAW_CAPTURE_ENABLE,
  input wire logic [3:0] RAW_CHANNEL_SELECT,
  input wire logic [15:0] RAW_FIRST_LINE,
  input wire logic [15:0] RAW_LAST_LINE,
  input wire logic [15:0] RAW_FIRST_PIXEL,
  input wire logic [15:0] RAW_SAMPLES_PER_LINE,
  // host hold and read
  input wire logic [2:0] HOST_HOLD,
  input wire logic [1:0] STATUS_SEL,
  // memory write port
  output logic MEM_WR_VALID,
  output logic [31:0] MEM_WR_ADDR,
  output logic [31:0] MEM_WR_DATA,
  input wire logic MEM_WR_READY,
  // status answer
  output logic [31:0] BUFFER_BASE_ADDRESS,
  output logic [31:0] BUFFER_RAW_REGION_OFFSET,
  output logic [15:0] STAT_WIDTH,
  output logic [15:0] STAT_HEIGHT,
  output logic STAT_SAMPLE_SIZE,
  output logic [31:0] STAT_TIMESTAMP,
  output logic [31:0] STAT_FRAME_NUMBER,
  output logic [15:0] STAT_PIXELS_WRITTEN,
  output logic [15:0] BUFFER_LINES_WRITTEN,
  output logic [2:0] BUFFER_DONE_FLAG,
  output logic [2:0] BUFFER_WRITE_LOCK,
  output logic PIXEL_DROP
);
  fbm_fifo_if fq ();
  fbm_pkg::fbm_state_t state_reg;
  logic [1:0] wbuf_reg;
  logic [15:0] pix_reg;
  logic [15:0] line_reg;
  logic [31:0] frame_cnt_reg;
  logic [15:0] raw_cnt_reg;
  logic [31:0] raw_wr_reg;
  logic [31:0] ts_reg [3];
  logic [31:0] fn_reg [3];
  logic [15:0] w_reg [3];
  logic [15:0] h_reg [3];
  logic ss_reg [3];
  logic [15:0] pw_reg [3];
  logic [15:0] lw_reg [3];
  logic [31:0] rawoff_reg [3];
  logic [2:0] done_reg;
  logic [1:0] next_buf;
  logic [15:0] raw_sample;
  logic raw_line_ok;
  logic raw_take;
  logic pix_take;
  logic frame_go;
  logic [1:0] wbuf_at;
  logic [31:0] pix_bytes;
  logic [15:0] raw_limit;
  logic frame_last;
  logic wr_sel_raw;
  logic [15:0] pix_next;
  logic [15:0] line_next;

  // base address of a buffer for the active layout
  function automatic logic [31:0] base_of(input logic [1:0] b, input logic big);
    logic [31:0] r;
    r = fbm_pkg::BASE3_0;
    if (big) begin
      r = (b == 2'h1) ? fbm_pkg::BASE2_1 : fbm_pkg::BASE2_0;
    end else begin
      case (b)
        2'h1: r = fbm_pkg::BASE3_1;
        2'h2: r = fbm_pkg::BASE3_2;
        default: r = fbm_pkg::BASE3_0;
      endcase
    end
    return r;
  endfunction : base_of

  // round a sample count up to a multiple of 1024
  function automatic logic [15:0] round_blk(input logic [15:0] n);
    logic [16:0] s;
    s = {1'b0, n} + 17'h003FF;
    return {s[15:10], 10'h000};
  endfunction : round_blk

  // choose next buffer not held, not busy
  always_comb begin
    next_buf = fbm_pkg::NO_BUF;
    for (int k = 2; k >= 0; k--) begin
      if (!HOST_HOLD[k] && !(LARGE_BUFFER_LAYOUT && k == 2)) begin
        if (!(state_reg == fbm_pkg::FBM_FILL && wbuf_reg == 2'(k))) begin
          next_buf = 2'(k);
        end
      end
    end
  end

  assign raw_sample = ADC_SAMPLES[RAW_CHANNEL_SELECT*16 +: 16];
  assign raw_limit = round_blk(RAW_SAMPLES_PER_LINE);
  assign raw_line_ok = RAW_CAPTURE_ENABLE && (line_reg >= RAW_FIRST_LINE)
    && (line_reg <= RAW_LAST_LINE);
  assign raw_take = (state_reg == fbm_pkg::FBM_FILL) && raw_line_ok
    && (pix_reg >= RAW_FIRST_PIXEL) && (raw_cnt_reg < raw_limit)
    && !PIXEL_STROBE;
  assign frame_go = PIXEL_STROBE && FRAME_MARK && (next_buf != fbm_pkg::NO_BUF);
  // the frame start strobe carries the first pixel of the frame
  assign pix_take = frame_go || ((state_reg == fbm_pkg::FBM_FILL) && PIXEL_STROBE && !FRAME_MARK
    && !frame_last);
  assign wbuf_at = frame_go ? next_buf : wbuf_reg;
  assign pix_bytes = SAMPLE_SIZE_SELECT ? 32'h00000004 : 32'h00000002;
  // counters hold pixels done in the line and the zero based line index
  assign pix_next = (frame_go || LINE_MARK) ? 16'h0001 : pix_reg + 16'h0001;
  assign line_next = frame_go ? fbm_pkg::CNT_RESET : (LINE_MARK ? line_reg + 16'h0001 : line_reg);
  assign frame_last = (line_reg == LINES_PER_OUTPUT - 16'h0001) && (pix_reg == PIXELS_PER_OUTPUT);
  assign wr_sel_raw = raw_take;

  // frame sequencing
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state_reg <= fbm_pkg::FBM_IDLE;
      wbuf_reg <= 2'h0;
      frame_cnt_reg <= 32'h00000000;
    end else if (PIXEL_STROBE && FRAME_MARK && next_buf != fbm_pkg::NO_BUF) begin
      state_reg <= fbm_pkg::FBM_FILL;
      wbuf_reg <= next_buf;
      frame_cnt_reg <= frame_cnt_reg + 32'h00000001;
    end else if (state_reg == fbm_pkg::FBM_FILL && (frame_last || HOST_HOLD[wbuf_reg])) begin
      state_reg <= fbm_pkg::FBM_IDLE;
    end
  end

  // pixel and line counters
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      pix_reg <= fbm_pkg::CNT_RESET;
      line_reg <= fbm_pkg::CNT_RESET;
      raw_cnt_reg <= fbm_pkg::CNT_RESET;
    end else if (pix_take) begin
      pix_reg <= pix_next;
      line_reg <= line_next;
      if (frame_go || LINE_MARK) begin
        raw_cnt_reg <= fbm_pkg::CNT_RESET;
      end
    end else if (PIXEL_STROBE && FRAME_MARK) begin
      pix_reg <= fbm_pkg::CNT_RESET;
      line_reg <= fbm_pkg::CNT_RESET;
      raw_cnt_reg <= fbm_pkg::CNT_RESET;
    end else if (raw_take && fq.in_ready) begin
      raw_cnt_reg <= raw_cnt_reg + 16'h0001;
    end
  end

  // raw write pointer within the buffer
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      raw_wr_reg <= 32'h00000000;
    end else if (PIXEL_STROBE && FRAME_MARK) begin
      raw_wr_reg <= 32'h00000000;
    end else if (raw_take && fq.in_ready) begin
      raw_wr_reg <= raw_wr_reg + 32'h00000002;
    end
  end

  // per buffer info and completion
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      done_reg <= 3'h0;
      for (int k = 0; k < 3; k++) begin
        ts_reg[k] <= 32'h00000000;
        fn_reg[k] <= 32'h00000000;
        w_reg[k] <= fbm_pkg::CNT_RESET;
        h_reg[k] <= fbm_pkg::CNT_RESET;
        ss_reg[k] <= 1'b0;
        pw_reg[k] <= fbm_pkg::CNT_RESET;
        lw_reg[k] <= fbm_pkg::CNT_RESET;
        rawoff_reg[k] <= 32'h00000000;
      end
    end else if (PIXEL_STROBE && FRAME_MARK && next_buf != fbm_pkg::NO_BUF) begin
      done_reg[next_buf] <= 1'b0;
      ts_reg[next_buf] <= TIMESTAMP;
      fn_reg[next_buf] <= frame_cnt_reg + 32'h00000001;
      w_reg[next_buf] <= PIXELS_PER_OUTPUT;
      h_reg[next_buf] <= LINES_PER_OUTPUT;
      ss_reg[next_buf] <= SAMPLE_SIZE_SELECT;
      pw_reg[next_buf] <= pix_next;
      lw_reg[next_buf] <= fbm_pkg::CNT_RESET;
      rawoff_reg[next_buf] <= (32'(PIXELS_PER_OUTPUT) * 32'(LINES_PER_OUTPUT) * pix_bytes
        + fbm_pkg::RAW_BLOCK - 32'h00000001) & ~(fbm_pkg::RAW_BLOCK - 32'h00000001);
      // completion of the old frame wins over the new frame start
      if (state_reg == fbm_pkg::FBM_FILL && frame_last) begin
        done_reg[wbuf_reg] <= 1'b1;
        lw_reg[wbuf_reg] <= line_reg + 16'h0001;
      end
    end else if (state_reg == fbm_pkg::FBM_FILL) begin
      if (pix_take) begin
        pw_reg[wbuf_reg] <= pix_next;
        if (LINE_MARK) begin
          lw_reg[wbuf_reg] <= line_reg + 16'h0001;
        end
      end
      if (frame_last) begin
        done_reg[wbuf_reg] <= 1'b1;
        lw_reg[wbuf_reg] <= line_reg + 16'h0001;
      end
    end
  end

  // push pixel or raw words into the write fifo
  always_comb begin
    fq.in_valid = pix_take || raw_take;
    if (wr_sel_raw) begin
      fq.in_data = {base_of(wbuf_reg, LARGE_BUFFER_LAYOUT) + rawoff_reg[wbuf_reg] + raw_wr_reg,
        16'h0000, raw_sample};
    end else begin
      fq.in_data = {base_of(wbuf_at, LARGE_BUFFER_LAYOUT)
        + (32'(line_next) * 32'(PIXELS_PER_OUTPUT) + 32'(pix_next) - 32'h00000001) * pix_bytes, PIXEL_DATA};
    end
  end

  fbm_fifo #(
    .WIDTH(fbm_pkg::ADDR_W + fbm_pkg::PIX_W),
    .DEPTH(fbm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(MCLK),
    .rst(SYS_RST),
    .f(fq)
  );

  // memory write side, registered
  assign fq.out_ready = !MEM_WR_VALID || MEM_WR_READY;
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      MEM_WR_VALID <= 1'b0;
      MEM_WR_ADDR <= 32'h00000000;
      MEM_WR_DATA <= 32'h00000000;
    end else if (fq.out_ready) begin
      MEM_WR_VALID <= fq.out_valid;
      MEM_WR_ADDR <= fq.out_data[63:32];
      MEM_WR_DATA <= fq.out_data[31:0];
    end
  end

  // pixel lost when fifo is full
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      PIXEL_DROP <= 1'b0;
    end else begin
      PIXEL_DROP <= pix_take && !fq.in_ready;
    end
  end

  // status answer for selected buffer
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      BUFFER_BASE_ADDRESS <= fbm_pkg::BASE3_0;
      BUFFER_RAW_REGION_OFFSET <= 32'h00000000;
      STAT_WIDTH <= fbm_pkg::CNT_RESET;
      STAT_HEIGHT <= fbm_pkg::CNT_RESET;
      STAT_SAMPLE_SIZE <= 1'b0;
      STAT_TIMESTAMP <= 32'h00000000;
      STAT_FRAME_NUMBER <= 32'h00000000;
      STAT_PIXELS_WRITTEN <= fbm_pkg::CNT_RESET;
      BUFFER_LINES_WRITTEN <= fbm_pkg::CNT_RESET;
      BUFFER_DONE_FLAG <= 3'h0;
      BUFFER_WRITE_LOCK <= 3'h0;
    end else begin
      BUFFER_BASE_ADDRESS <= base_of(STATUS_SEL, LARGE_BUFFER_LAYOUT);
      BUFFER_RAW_REGION_OFFSET <= rawoff_reg[STATUS_SEL[1] ? 2 : STATUS_SEL[0]];
      STAT_WIDTH <= w_reg[STATUS_SEL[1] ? 2 : STATUS_SEL[0]];
      STAT_HEIGHT <= h_reg[STATUS_SEL[1] ? 2 : STATUS_SEL[0]];
      STAT_SAMPLE_SIZE <= ss_reg[STATUS_SEL[1] ? 2 : STATUS_SEL[0]];
      STAT_TIMESTAMP <= ts_reg[STATUS_SEL[1] ? 2 : STATUS_SEL[0]];
      STAT_FRAME_NUMBER <= fn_reg[STATUS_SEL[1] ? 2 : STATUS_SEL[0]];
      STAT_PIXELS_WRITTEN <= pw_reg[STATUS_SEL[1] ? 2 : STATUS_SEL[0]];
      BUFFER_LINES_WRITTEN <= lw_reg[STATUS_SEL[1] ? 2 : STATUS_SEL[0]];
      BUFFER_DONE_FLAG <= done_reg;
      BUFFER_WRITE_LOCK <= (state_reg == fbm_pkg::FBM_FILL) ? (3'h1 << wbuf_reg) : 3'h0;
    end
  end

  a_hold_no_write: assert property (@(posedge MCLK) disable iff (SYS_RST)
    state_reg == fbm_pkg::FBM_FILL && HOST_HOLD[wbuf_reg] |=> state_reg == fbm_pkg::FBM_IDLE)
    else $error("held buffer still being written");
  a_raw_off_disabled: assert property (@(posedge MCLK) disable iff (SYS_RST)
    !RAW_CAPTURE_ENABLE |-> !raw_take) else $error("raw write while disabled");
  a_raw_line_window: assert property (@(posedge MCLK) disable iff (SYS_RST)
    raw_take |-> line_reg >= RAW_FIRST_LINE && line_reg <= RAW_LAST_LINE)
    else $error("raw write outside line window");
  a_raw_count_limit: assert property (@(posedge MCLK) disable iff (SYS_RST)
    raw_take |-> raw_cnt_reg < raw_limit && raw_limit[9:0] == 10'h000)
    else $error("raw count beyond rounded limit");
  a_frame_done_set: assert property (@(posedge MCLK) disable iff (SYS_RST)
    state_reg == fbm_pkg::FBM_FILL && frame_last && !(PIXEL_STROBE && FRAME_MARK)
    |=> done_reg[$past(wbuf_reg)] && state_reg == fbm_pkg::FBM_IDLE)
    else $error("frame done flag not set");
  a_frame_start_lock: assert property (@(posedge MCLK) disable iff (SYS_RST)
    PIXEL_STROBE && FRAME_MARK && next_buf != fbm_pkg::NO_BUF
    |=> state_reg == fbm_pkg::FBM_FILL && wbuf_reg == $past(next_buf) && !HOST_HOLD[$past(next_buf)])
    else $error("frame start did not lock free buffer");
  a_big_layout_base: assert property (@(posedge MCLK) disable iff (SYS_RST)
    LARGE_BUFFER_LAYOUT && STATUS_SEL == 2'h1 ##1 $stable(STATUS_SEL) && LARGE_BUFFER_LAYOUT
    |-> BUFFER_BASE_ADDRESS == fbm_pkg::BASE2_1) else $error("wrong large layout base");
  a_big_no_third: assert property (@(posedge MCLK) disable iff (SYS_RST)
    LARGE_BUFFER_LAYOUT |-> next_buf != 2'h2) else $error("third buffer chosen in large layout");
  a_normal_base: assert property (@(posedge MCLK) disable iff (SYS_RST)
    !LARGE_BUFFER_LAYOUT && STATUS_SEL == 2'h2 ##1 $stable(STATUS_SEL) && !LARGE_BUFFER_LAYOUT
    |-> BUFFER_BASE_ADDRESS == fbm_pkg::BASE3_2) else $error("wrong normal base");
  a_lock_one_hot: assert property (@(posedge MCLK) disable iff (SYS_RST)
    $onehot0(BUFFER_WRITE_LOCK)) else $error("more than one buffer locked for writing");
  a_lines_current: assert property (@(posedge MCLK) disable iff (SYS_RST)
    state_reg == fbm_pkg::FBM_FILL && pix_take && LINE_MARK && !FRAME_MARK
    |=> lw_reg[$past(wbuf_reg)] == $past(line_reg) + 16'h0001)
    else $error("lines written count not current");
  a_first_pixel_base: assert property (@(posedge MCLK) disable iff (SYS_RST)
    frame_go |-> fq.in_valid && fq.in_data[63:32] == base_of(next_buf, LARGE_BUFFER_LAYOUT))
    else $error("first pixel not at buffer base");
endmodule : fbm_manager

/* File: design/fbm_pkg.sv */
// package of constants and types for the frame buffer manager
package fbm_pkg;
  localparam int ADDR_W = 32;
  localparam int PIX_W = 32;
  localparam int CNT_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int NUM_BUF = 3;
  localparam int RAW_CHANNELS = 16;
  localparam logic [ADDR_W-1:0] BASE3_0 = 32'hA0000000;
  localparam logic [ADDR_W-1:0] BASE3_1 = 32'hC0000000;
  localparam logic [ADDR_W-1:0] BASE3_2 = 32'hE0000000;
  localparam logic [ADDR_W-1:0] BASE2_0 = 32'hA0000000;
  localparam logic [ADDR_W-1:0] BASE2_1 = 32'hD0000000;
  localparam logic [ADDR_W-1:0] BUF3_SIZE = 32'h20000000;
  localparam logic [ADDR_W-1:0] BUF2_SIZE = 32'h30000000;
  localparam logic [ADDR_W-1:0] RAW_BLOCK = 32'h00000400;
  localparam logic [1:0] NO_BUF = 2'h3;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  typedef enum logic [1:0] {
    FBM_IDLE = 2'b00,
    FBM_FILL = 2'b01
  } fbm_state_t;
endpackage : fbm_pkg

/* File: design/fbm_fifo_if.sv */
// interface carrying write words between the manager and its fifo
`timescale 1ns/1ps
interface fbm_fifo_if;
  logic in_valid;
  logic in_ready;
  logic [fbm_pkg::ADDR_W+fbm_pkg::PIX_W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [fbm_pkg::ADDR_W+fbm_pkg::PIX_W-1:0] out_data;
  modport src (output in_valid, output in_data, input in_ready);
  modport fifo (input in_valid, input in_data, output in_ready,
    output out_valid, output out_data, input out_ready);
  modport snk (input out_valid, input out_data, output out_ready);
endinterface : fbm_fifo_if

/* File: design/fbm_fifo.sv */
// parameterised fifo for address and data words
`timescale 1ns/1ps
module fbm_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data path
  fbm_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;
  assign f.in_ready = (count_reg != (AW+1)'(DEPTH));
  assign f.out_valid = (count_reg != '0);
  assign f.out_data = mem[rd_ptr_reg];
  assign push = f.in_valid && f.in_ready;
  assign pop = f.out_valid && f.out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= f.in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  a_fifo_no_overflow: assert property (@(posedge clk) disable iff (rst)
    count_reg <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : fbm_fifo

/* File: bench/fbm_host_model.sv */
// host side model: memory sink with stalls, buffer hold and status select
`timescale 1ns/1ps
module fbm_host_model (
  // clock
  input wire logic clk,
  // memory write port
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_data,
  output logic mem_ready,
  // host controls
  output logic [2:0] hold,
  output logic [1:0] sel
);
  logic slow = 1'b0;
  logic [31:0] addr_q[$];
  logic [31:0] data_q[$];
  initial begin
    mem_ready = 1'b1;
    hold = 3'h0;
    sel = 2'h0;
  end
  // log every accepted word
  always @(posedge clk) begin
    if (mem_valid && mem_ready) begin
      addr_q.push_back(mem_addr);
      data_q.push_back(mem_data);
    end
  end
  // ready every other cycle when slow
  always @(negedge clk) begin
    mem_ready <= !slow || !mem_ready;
  end
  // hold a buffer before fetching it, then let status settle
  task automatic host_ctl(input logic [2:0] h, input logic [1:0] s);
    @(negedge clk);
    hold = h;
    sel = s;
    repeat (2) @(negedge clk);
  endtask : host_ctl
  // whole frame fetch length in 1024 byte blocks
  function automatic int fetch_blocks(input int w, input int h, input logic wide);
    return (w * h * (wide ? 4 : 2) + 1023) / 1024;
  endfunction : fetch_blocks
endmodule : fbm_host_model

/* File: bench/fbm_manager_tb.sv */
// self-checking bench for the frame buffer manager
`timescale 1ns/1ps
module fbm_manager_tb;
  localparam int NP = 4;
  localparam int NL = 2;
  logic MCLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic FRAME_MARK = 1'b0;
  logic LINE_MARK = 1'b0;
  logic PIXEL_STROBE = 1'b0;
  logic [31:0] PIXEL_DATA = 32'h0;
  logic [31:0] TIMESTAMP = 32'h0;
  logic [255:0] ADC_SAMPLES;
  logic SAMPLE_SIZE_SELECT = 1'b0;
  logic LARGE_BUFFER_LAYOUT = 1'b0;
  logic RAW_CAPTURE_ENABLE = 1'b0;
  logic [3:0] RAW_CHANNEL_SELECT = 4'h0;
  logic [15:0] RAW_FIRST_LINE = 16'h0;
  logic [15:0] RAW_LAST_LINE = 16'hFFFF;
  logic [15:0] RAW_FIRST_PIXEL = 16'h0;
  logic [2:0] HOST_HOLD;
  logic [1:0] STATUS_SEL;
  logic MEM_WR_VALID, MEM_WR_READY, STAT_SAMPLE_SIZE, PIXEL_DROP;
  logic [31:0] MEM_WR_ADDR, MEM_WR_DATA, BUFFER_BASE_ADDRESS, BUFFER_RAW_REGION_OFFSET;
  logic [31:0] STAT_TIMESTAMP, STAT_FRAME_NUMBER;
  logic [15:0] STAT_WIDTH, STAT_HEIGHT, STAT_PIXELS_WRITTEN, BUFFER_LINES_WRITTEN;
  logic [2:0] BUFFER_DONE_FLAG, BUFFER_WRITE_LOCK;
  logic [32:0] neg_cfg[3] = '{{1'b0, 16'h0, 16'h0}, {1'b1, 16'h00FF, 16'h0}, {1'b1, 16'h0, 16'h00FF}};
  logic [31:0] bases3[3] = '{32'hA0000000, 32'hC0000000, 32'hE0000000};
  int fails = 0;
  int n_tests = 0;

  always #5 MCLK = ~MCLK;

  fbm_manager dut (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .FRAME_MARK(FRAME_MARK), .LINE_MARK(LINE_MARK),
    .PIXEL_STROBE(PIXEL_STROBE), .PIXEL_DATA(PIXEL_DATA), .TIMESTAMP(TIMESTAMP), .ADC_SAMPLES(ADC_SAMPLES),
    .PIXELS_PER_OUTPUT(16'(NP)), .LINES_PER_OUTPUT(16'(NL)), .SAMPLE_SIZE_SELECT(SAMPLE_SIZE_SELECT),
    .LARGE_BUFFER_LAYOUT(LARGE_BUFFER_LAYOUT), .RAW_CAPTURE_ENABLE(RAW_CAPTURE_ENABLE),
    .RAW_CHANNEL_SELECT(RAW_CHANNEL_SELECT), .RAW_FIRST_LINE(RAW_FIRST_LINE), .RAW_LAST_LINE(RAW_LAST_LINE),
    .RAW_FIRST_PIXEL(RAW_FIRST_PIXEL), .RAW_SAMPLES_PER_LINE(16'h0001), .HOST_HOLD(HOST_HOLD),
    .STATUS_SEL(STATUS_SEL), .MEM_WR_VALID(MEM_WR_VALID), .MEM_WR_ADDR(MEM_WR_ADDR),
    .MEM_WR_DATA(MEM_WR_DATA), .MEM_WR_READY(MEM_WR_READY), .BUFFER_BASE_ADDRESS(BUFFER_BASE_ADDRESS),
    .BUFFER_RAW_REGION_OFFSET(BUFFER_RAW_REGION_OFFSET), .STAT_WIDTH(STAT_WIDTH), .STAT_HEIGHT(STAT_HEIGHT),
    .STAT_SAMPLE_SIZE(STAT_SAMPLE_SIZE), .STAT_TIMESTAMP(STAT_TIMESTAMP),
    .STAT_FRAME_NUMBER(STAT_FRAME_NUMBER), .STAT_PIXELS_WRITTEN(STAT_PIXELS_WRITTEN),
    .BUFFER_LINES_WRITTEN(BUFFER_LINES_WRITTEN), .BUFFER_DONE_FLAG(BUFFER_DONE_FLAG),
    .BUFFER_WRITE_LOCK(BUFFER_WRITE_LOCK), .PIXEL_DROP(PIXEL_DROP)
  );

  fbm_host_model host (
    .clk(MCLK), .mem_valid(MEM_WR_VALID), .mem_addr(MEM_WR_ADDR), .mem_data(MEM_WR_DATA),
    .mem_ready(MEM_WR_READY), .hold(HOST_HOLD), .sel(STATUS_SEL)
  );

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    if (fails == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // one frame of NP x NL pixels, then sort logged words into pixel and raw
  task automatic run_frame(input logic [31:0] base, input logic wide, input int gap, input logic [2:0] lock,
    input logic exp_raw);
    int k;
    int raw;
    logic [31:0] a;
    k = 0;
    raw = 0;
    host.addr_q.delete();
    host.data_q.delete();
    @(negedge MCLK);
    SAMPLE_SIZE_SELECT = wide;
    for (int i = 0; i < NP * NL; i++) begin
      @(negedge MCLK);
      if (i == 2) chk("write_lock", BUFFER_WRITE_LOCK, lock);
      PIXEL_STROBE = 1'b1;
      FRAME_MARK = (i == 0);
      LINE_MARK = (i > 0) && (i % NP == 0);
      PIXEL_DATA = 32'hC000 + i;
      if (gap > 0) begin
        @(negedge MCLK);
        PIXEL_STROBE = 1'b0;
        repeat (gap - 1) @(negedge MCLK);
      end
    end
    @(negedge MCLK);
    PIXEL_STROBE = 1'b0;
    FRAME_MARK = 1'b0;
    LINE_MARK = 1'b0;
    repeat (60) @(negedge MCLK);
    foreach (host.addr_q[j]) begin
      a = host.addr_q[j] - base;
      if (a >= 32'h400) begin
        chk("raw_addr", a, 32'h400 + 2 * raw);
        chk("raw_data", host.data_q[j][15:0], 16'h1000 + RAW_CHANNEL_SELECT);
        raw++;
      end else begin
        chk("pix_addr", a, k * (wide ? 4 : 2));
        chk("pix_data", host.data_q[j], 32'hC000 + k);
        k++;
      end
    end
    chk("pix_count", k, NP * NL);
    chk("raw_more_than_line", raw > NL, exp_raw);
    chk("done_flag", BUFFER_DONE_FLAG & lock, lock);
  endtask : run_frame

  initial begin
    for (int n = 0; n < 16; n++) begin
      ADC_SAMPLES[16*n +: 16] = 16'h1000 + n[15:0];
    end
    repeat (5) @(posedge MCLK);
    @(negedge MCLK);
    SYS_RST = 1'b0;
    chk("base_reset", BUFFER_BASE_ADDRESS, 32'hA0000000);
    chk("done_reset", BUFFER_DONE_FLAG, 3'h0);
    chk("lock_reset", BUFFER_WRITE_LOCK, 3'h0);
    foreach (bases3[s]) begin
      host.host_ctl(3'h0, s[1:0]);
      chk("base_normal", BUFFER_BASE_ADDRESS, bases3[s]);
    end
    // back to back 16 bit frame into buffer 0
    TIMESTAMP = 32'h5A5A0001;
    host.host_ctl(3'h0, 2'h0);
    run_frame(32'hA0000000, 1'b0, 0, 3'h1, 1'b0);
    chk("stat_width", STAT_WIDTH, NP);
    chk("stat_height", STAT_HEIGHT, NL);
    chk("stat_size", STAT_SAMPLE_SIZE, 1'b0);
    chk("stat_time", STAT_TIMESTAMP, 32'h5A5A0001);
    chk("lines_done", BUFFER_LINES_WRITTEN, NL);
    chk("pixels_done", STAT_PIXELS_WRITTEN, NP);
    chk("stat_frame", STAT_FRAME_NUMBER, 1);
    chk("raw_offset", BUFFER_RAW_REGION_OFFSET, host.fetch_blocks(NP, NL, 1'b0) * 1024);
    // buffer 0 held, slow memory, 32 bit pixels: writer moves to buffer 1
    host.host_ctl(3'h1, 2'h1);
    host.slow = 1'b1;
    run_frame(32'hC0000000, 1'b1, 0, 3'h2, 1'b0);
    host.slow = 1'b0;
    chk("done_held", BUFFER_DONE_FLAG, 3'h3);
    chk("stat_size32", STAT_SAMPLE_SIZE, 1'b1);
    // raw capture from every channel
    RAW_CAPTURE_ENABLE = 1'b1;
    for (int c = 0; c < 16; c++) begin
      RAW_CHANNEL_SELECT = c[3:0];
      run_frame(32'hC0000000, 1'b0, 3, 3'h2, 1'b1);
    end
    // disabled, line window missed, pixel start missed
    foreach (neg_cfg[j]) begin
      {RAW_CAPTURE_ENABLE, RAW_FIRST_LINE, RAW_FIRST_PIXEL} = neg_cfg[j];
      run_frame(32'hC0000000, 1'b0, 3, 3'h2, 1'b0);
    end
    // two buffer layout with both buffers held: nothing may be locked
    LARGE_BUFFER_LAYOUT = 1'b1;
    host.host_ctl(3'h3, 2'h1);
    chk("base_large", BUFFER_BASE_ADDRESS, 32'hD0000000);
    host.addr_q.delete();
    PIXEL_STROBE = 1'b1;
    FRAME_MARK = 1'b1;
    @(negedge MCLK);
    PIXEL_STROBE = 1'b0;
    FRAME_MARK = 1'b0;
    repeat (10) @(negedge MCLK);
    chk("lock_none", BUFFER_WRITE_LOCK, 3'h0);
    chk("writes_none", host.addr_q.size(), 0);
    host.host_ctl(3'h2, 2'h0);
    run_frame(32'hA0000000, 1'b0, 0, 3'h1, 1'b0);
    wrap_up();
  end

  initial begin
    #500000;
    fails++;
    wrap_up();
  end
endmodule : fbm_manager_tb
